// >>> fault_pkg.sv
package fault_pkg;
  // Clock and timing
  localparam int CLK_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int QUARTER_MS = 250;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int QUARTER_CYCLES = QUARTER_MS * MS_CYCLES;
  // Blink shape in quarter-second units
  localparam logic [4:0] SET_ON_Q = 5'h04;
  localparam logic [4:0] SET_PERIOD_Q = 5'h08;
  localparam logic [4:0] GAP_Q = 5'h08;
  // Modbus ASCII
  localparam logic [7:0] ASC_COLON = 8'h3a;
  localparam logic [7:0] ASC_CR = 8'h0d;
  localparam logic [7:0] ASC_LF = 8'h0a;
  localparam logic [3:0] FRAME_BYTES = 4'h7;
  localparam logic [3:0] EXC_LAST = 4'ha;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] FN_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_COMM = 8'h04;
  localparam logic [7:0] EXC_LRC = 8'h09;
  localparam logic [15:0] REG_CMD = 16'h2000;
  localparam logic [15:0] REG_FREQ = 16'h2001;
  localparam logic [15:0] REG_RESET = 16'h2002;
  localparam logic [15:0] REG_STAT_FIRST = 16'h2100;
  localparam logic [15:0] REG_STAT_END = 16'h2107;
  localparam logic [15:0] CMD_UNUSED = 16'hffcc;
  localparam logic [15:0] RESET_UNUSED = 16'hfffd;
  localparam int RESET_BIT = 1;
  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WDT_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_WDT_COUNT = 8'h0c;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_COMMFAIL_BIT = 1;
  localparam int CTRL_SLAVE_LSB = 8;
  localparam logic [7:0] SLAVE_RST = 8'h01;
  localparam logic [15:0] WDT_LIMIT_RST = 16'h0000;

  typedef enum logic [2:0] {
    CLS_NONE = 3'b000,
    CLS_SETTING = 3'b001,
    CLS_HWFAIL = 3'b010,
    CLS_OVERCUR = 3'b011,
    CLS_OVERVOLT = 3'b100,
    CLS_UNDERVOLT = 3'b101,
    CLS_OVERHEAT = 3'b110,
    CLS_OVERLOAD = 3'b111
  } alarm_cls_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
  endfunction

  // Bit 4 flags a character that is not a hex digit 0-9 or upper-case A-F
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_val = {1'b0, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hex_val = {1'b0, c[3:0] + 4'h9};
    end else begin
      hex_val = 5'h10;
    end
  endfunction
endpackage

// >>> modbus_ascii_rx.sv
`timescale 1ns/1ns
module modbus_ascii_rx import fault_pkg::*; (
  // Clock
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Characters
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  // Decoded frame
  output logic o_done,
  output logic o_len_ok,
  output logic o_lrc_ok,
  output logic [7:0] o_addr,
  output logic [7:0] o_func,
  output logic [15:0] o_reg,
  output logic [15:0] o_data
);
  logic in_r, in_nxt, half_r, half_nxt, bad_r, bad_nxt;
  logic done_nxt, len_ok_nxt, lrc_ok_nxt;
  logic [3:0] hi_r, hi_nxt, cnt_r, cnt_nxt;
  logic [7:0] sum_r, sum_nxt, addr_nxt, func_nxt;
  logic [15:0] reg_nxt, data_nxt;

  always_comb begin
    logic [4:0] dec;
    logic [7:0] byte_v;
    dec = hex_val(i_rx_char);
    byte_v = {hi_r, dec[3:0]};
    in_nxt = in_r;
    half_nxt = half_r;
    bad_nxt = bad_r;
    hi_nxt = hi_r;
    cnt_nxt = cnt_r;
    sum_nxt = sum_r;
    addr_nxt = o_addr;
    func_nxt = o_func;
    reg_nxt = o_reg;
    data_nxt = o_data;
    done_nxt = 1'b0;
    len_ok_nxt = o_len_ok;
    lrc_ok_nxt = o_lrc_ok;
    if (i_rx_valid) begin
      if (i_rx_char == ASC_COLON) begin
        in_nxt = 1'b1;
        half_nxt = 1'b0;
        bad_nxt = 1'b0;
        cnt_nxt = 4'h0;
        sum_nxt = 8'h00;
      end else if (in_r) begin
        if (i_rx_char == ASC_LF) begin
          in_nxt = 1'b0;
          done_nxt = 1'b1;
          len_ok_nxt = !bad_r && !half_r && cnt_r == FRAME_BYTES;
          lrc_ok_nxt = sum_r == 8'h00;
        end else if (i_rx_char == ASC_CR) begin
          in_nxt = in_r;
        end else if (dec[4]) begin
          bad_nxt = 1'b1;
        end else if (!half_r) begin
          hi_nxt = dec[3:0];
          half_nxt = 1'b1;
        end else begin
          half_nxt = 1'b0;
          sum_nxt = sum_r + byte_v;
          if (cnt_r <= FRAME_BYTES) begin
            cnt_nxt = cnt_r + 4'h1;
          end
          case (cnt_r)
            4'h0: addr_nxt = byte_v;
            4'h1: func_nxt = byte_v;
            4'h2: reg_nxt = {byte_v, o_reg[7:0]};
            4'h3: reg_nxt = {o_reg[15:8], byte_v};
            4'h4: data_nxt = {byte_v, o_data[7:0]};
            4'h5: data_nxt = {o_data[15:8], byte_v};
            default: sum_nxt = sum_r + byte_v;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_r <= 1'b0;
      half_r <= 1'b0;
      bad_r <= 1'b0;
      hi_r <= 4'h0;
      cnt_r <= 4'h0;
      sum_r <= 8'h00;
      o_done <= 1'b0;
      o_len_ok <= 1'b0;
      o_lrc_ok <= 1'b0;
      o_addr <= 8'h00;
      o_func <= 8'h00;
      o_reg <= 16'h0000;
      o_data <= 16'h0000;
    end else if (ce) begin
      in_r <= in_nxt;
      half_r <= half_nxt;
      bad_r <= bad_nxt;
      hi_r <= hi_nxt;
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
      o_done <= done_nxt;
      o_len_ok <= len_ok_nxt;
      o_lrc_ok <= lrc_ok_nxt;
      o_addr <= addr_nxt;
      o_func <= func_nxt;
      o_reg <= reg_nxt;
      o_data <= data_nxt;
    end
  end
endmodule

// >>> alarm_blinker.sv
`timescale 1ns/1ns
module alarm_blinker import fault_pkg::*; #(
  parameter int QUARTER_CYC = QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [2:0] i_cls,
  output logic o_led
);
  logic [31:0] tick_r, tick_nxt;
  logic [4:0] q_r, q_nxt;
  logic [2:0] cls_r, cls_nxt;
  logic led_nxt;

  always_comb begin
    logic [4:0] pulses;
    logic [4:0] period;
    pulses = {2'b00, i_cls} - 5'h02;
    period = (i_cls == CLS_SETTING) ? SET_PERIOD_Q : ({pulses[3:0], 1'b0} + GAP_Q);
    cls_nxt = i_cls;
    tick_nxt = tick_r + 32'h1;
    q_nxt = q_r;
    if (i_cls != cls_r) begin
      tick_nxt = 32'h0;
      q_nxt = 5'h00;
    end else if (tick_r >= 32'(QUARTER_CYC - 1)) begin
      tick_nxt = 32'h0;
      q_nxt = (q_r + 5'h01 >= period) ? 5'h00 : q_r + 5'h01;
    end
    case (i_cls)
      CLS_NONE: led_nxt = 1'b0;
      CLS_SETTING: led_nxt = q_r < SET_ON_Q;
      CLS_HWFAIL: led_nxt = 1'b1;
      default: led_nxt = q_r < {pulses[3:0], 1'b0} && !q_r[0];
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_r <= 32'h0;
      q_r <= 5'h00;
      cls_r <= CLS_NONE;
      o_led <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_nxt;
      q_r <= q_nxt;
      cls_r <= cls_nxt;
      o_led <= led_nxt;
    end
  end
endmodule

// >>> modbus_fault_alarm_logic.sv
`timescale 1ns/1ns
module modbus_fault_alarm_logic import fault_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int QUARTER_CYC = QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Serial characters
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_CHAR,
  input wire logic I_TX_READY,
  output logic O_TX_VALID,
  output logic [7:0] O_TX_CHAR,
  // Protection pins
  input wire logic I_OVERCUR,
  input wire logic I_OVERVOLT,
  input wire logic I_UNDERVOLT,
  input wire logic I_OVERHEAT,
  input wire logic I_OVERLOAD,
  input wire logic I_THERMAL,
  input wire logic I_HW_FAULT,
  input wire logic I_STOP_SW,
  input wire logic I_RUN_TERM,
  input wire logic [7:0] I_DIP,
  // Drive and alarm outputs
  output logic O_DRIVE_EN,
  output logic O_ALARM_O,
  output logic O_ALARM_OE,
  output logic O_LED
);
  logic [16:0] sync1_r, sync2_r;
  logic f_oc, f_ov, f_uv, f_oh, f_ol, f_th, f_hw, stop_s, run_s;
  logic [7:0] dip_s;
  logic frm_done, frm_len_ok, frm_lrc_ok;
  logic [7:0] frm_addr, frm_func;
  logic [15:0] frm_reg, frm_data;
  logic pready_nxt, pslverr_nxt, apb_wr;
  logic [31:0] prdata_nxt;
  logic [7:0] slave_r, slave_nxt;
  logic commfail_r, commfail_nxt, swreset_r, swreset_nxt;
  logic [15:0] wlimit_r, wlimit_nxt, wcnt_r, wcnt_nxt;
  logic [31:0] mscnt_r, mscnt_nxt;
  logic [7:0] lastexc_r, lastexc_nxt;
  logic wdt_exp;
  logic reply, msg_ok, serial_reset;
  logic [7:0] exc;
  logic latched_r, latched_nxt, running;
  alarm_cls_t cls_r, cls_nxt, fault_cls;
  logic [7:0] dip_ref_r, dip_ref_nxt;
  logic drive_nxt;
  tx_state_t tx_st_r, tx_st_nxt;
  logic [3:0] tx_idx_r, tx_idx_nxt;
  logic [7:0] tx_adr_r, tx_adr_nxt, tx_fn_r, tx_fn_nxt, tx_exc_r, tx_exc_nxt;
  logic [7:0] tx_lrc_r, tx_lrc_nxt, tx_char_nxt;
  logic tx_valid_nxt;

  function automatic logic [7:0] exc_char(input logic [3:0] i, input logic [7:0] a,
                                          input logic [7:0] f, input logic [7:0] e,
                                          input logic [7:0] l);
    case (i)
      4'h0: exc_char = ASC_COLON;
      4'h1: exc_char = hex_char(a[7:4]);
      4'h2: exc_char = hex_char(a[3:0]);
      4'h3: exc_char = hex_char(f[7:4]);
      4'h4: exc_char = hex_char(f[3:0]);
      4'h5: exc_char = hex_char(e[7:4]);
      4'h6: exc_char = hex_char(e[3:0]);
      4'h7: exc_char = hex_char(l[7:4]);
      4'h8: exc_char = hex_char(l[3:0]);
      4'h9: exc_char = ASC_CR;
      default: exc_char = ASC_LF;
    endcase
  endfunction

  // Pin synchroniser
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      sync1_r <= 17'h0;
      sync2_r <= 17'h0;
    end else if (I_CE) begin
      sync1_r <= {I_OVERCUR, I_OVERVOLT, I_UNDERVOLT, I_OVERHEAT, I_OVERLOAD, I_THERMAL,
                  I_HW_FAULT, I_STOP_SW, I_RUN_TERM, I_DIP};
      sync2_r <= sync1_r;
    end
  end
  assign {f_oc, f_ov, f_uv, f_oh, f_ol, f_th, f_hw, stop_s, run_s, dip_s} = sync2_r;

  modbus_ascii_rx u_rx (
    .clk(I_CLK),
    .nrst(I_NRST),
    .ce(I_CE),
    .i_rx_valid(I_RX_VALID),
    .i_rx_char(I_RX_CHAR),
    .o_done(frm_done),
    .o_len_ok(frm_len_ok),
    .o_lrc_ok(frm_lrc_ok),
    .o_addr(frm_addr),
    .o_func(frm_func),
    .o_reg(frm_reg),
    .o_data(frm_data)
  );

  // Frame judgement
  always_comb begin
    reply = 1'b0;
    msg_ok = 1'b0;
    exc = 8'h00;
    if (frm_done && frm_len_ok && frm_addr == slave_r) begin
      reply = 1'b1;
      if (!frm_lrc_ok) begin
        exc = EXC_LRC;
      end else if (commfail_r) begin
        exc = EXC_COMM;
      end else if (frm_func != FN_READ && frm_func != FN_WRITE) begin
        exc = EXC_FUNC;
      end else if (frm_func == FN_WRITE ? (frm_reg < REG_CMD || frm_reg > REG_RESET)
                   : (frm_reg < REG_STAT_FIRST || frm_reg >= REG_STAT_END)) begin
        exc = EXC_ADDR;
      end else if (frm_func == FN_WRITE ?
                   ((frm_reg == REG_CMD && (frm_data & CMD_UNUSED) != 16'h0) ||
                    (frm_reg == REG_RESET && (frm_data & RESET_UNUSED) != 16'h0)) :
                   (frm_data == 16'h0 || frm_data > REG_STAT_END - frm_reg)) begin
        exc = EXC_DATA;
      end else begin
        reply = 1'b0;
        msg_ok = 1'b1;
      end
    end
    serial_reset = swreset_r || (msg_ok && frm_func == FN_WRITE && frm_reg == REG_RESET &&
                                 frm_data[RESET_BIT]);
  end

  // APB registers and watchdog
  always_comb begin
    apb_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    pready_nxt = I_PSEL && I_PENABLE && !O_PREADY;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0;
    slave_nxt = slave_r;
    commfail_nxt = commfail_r;
    swreset_nxt = 1'b0;
    wlimit_nxt = wlimit_r;
    case (I_PADDR)
      ADDR_CTRL: prdata_nxt = {16'h0, slave_r, 6'h0, commfail_r, 1'b0};
      ADDR_STATUS: prdata_nxt = {16'h0, lastexc_r, 2'b00, wdt_exp, O_DRIVE_EN, cls_r, latched_r};
      ADDR_WDT_LIMIT: prdata_nxt = {16'h0, wlimit_r};
      ADDR_WDT_COUNT: prdata_nxt = {16'h0, wcnt_r};
      default: pslverr_nxt = pready_nxt;
    endcase
    if (apb_wr && I_PADDR == ADDR_CTRL) begin
      slave_nxt = I_PWDATA[CTRL_SLAVE_LSB +: 8];
      commfail_nxt = I_PWDATA[CTRL_COMMFAIL_BIT];
      swreset_nxt = I_PWDATA[CTRL_RESET_BIT];
    end
    if (apb_wr && I_PADDR == ADDR_WDT_LIMIT) begin
      wlimit_nxt = I_PWDATA[15:0];
    end
    lastexc_nxt = reply ? exc : lastexc_r;
    wdt_exp = wlimit_r != 16'h0 && wcnt_r >= wlimit_r;
    mscnt_nxt = (mscnt_r >= 32'(MS_CYC - 1)) ? 32'h0 : mscnt_r + 32'h1;
    wcnt_nxt = wcnt_r;
    if (mscnt_r >= 32'(MS_CYC - 1) && wcnt_r != 16'hffff) begin
      wcnt_nxt = wcnt_r + 16'h1;
    end
    if (msg_ok) begin
      wcnt_nxt = 16'h0;
      mscnt_nxt = 32'h0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0;
      slave_r <= SLAVE_RST;
      commfail_r <= 1'b0;
      swreset_r <= 1'b0;
      wlimit_r <= WDT_LIMIT_RST;
      wcnt_r <= 16'h0;
      mscnt_r <= 32'h0;
      lastexc_r <= 8'h00;
    end else if (I_CE) begin
      O_PREADY <= pready_nxt;
      O_PSLVERR <= pslverr_nxt;
      O_PRDATA <= pready_nxt ? prdata_nxt : 32'h0;
      slave_r <= slave_nxt;
      commfail_r <= commfail_nxt;
      swreset_r <= swreset_nxt;
      wlimit_r <= wlimit_nxt;
      wcnt_r <= wcnt_nxt;
      mscnt_r <= mscnt_nxt;
      lastexc_r <= lastexc_nxt;
    end
  end

  // Protection latch
  always_comb begin
    running = run_s && !stop_s;
    dip_ref_nxt = running ? dip_ref_r : dip_s;
    fault_cls = CLS_NONE;
    if (f_hw || wdt_exp) begin
      fault_cls = CLS_HWFAIL;
    end else if (f_oc) begin
      fault_cls = CLS_OVERCUR;
    end else if (f_ov) begin
      fault_cls = CLS_OVERVOLT;
    end else if (f_uv) begin
      fault_cls = CLS_UNDERVOLT;
    end else if (f_oh) begin
      fault_cls = CLS_OVERHEAT;
    end else if (f_ol || f_th) begin
      fault_cls = CLS_OVERLOAD;
    end else if (running && dip_s != dip_ref_r) begin
      fault_cls = CLS_SETTING;
    end
    latched_nxt = latched_r;
    cls_nxt = cls_r;
    if (!latched_r && fault_cls != CLS_NONE) begin
      latched_nxt = 1'b1;
      cls_nxt = fault_cls;
    end else if (latched_r && fault_cls == CLS_NONE && (stop_s || !run_s || serial_reset)) begin
      latched_nxt = 1'b0;
      cls_nxt = CLS_NONE;
    end
    drive_nxt = running && !latched_nxt && fault_cls == CLS_NONE;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      latched_r <= 1'b0;
      cls_r <= CLS_NONE;
      dip_ref_r <= 8'h00;
      O_DRIVE_EN <= 1'b0;
      O_ALARM_O <= 1'b0;
      O_ALARM_OE <= 1'b0;
    end else if (I_CE) begin
      latched_r <= latched_nxt;
      cls_r <= cls_nxt;
      dip_ref_r <= dip_ref_nxt;
      O_DRIVE_EN <= drive_nxt;
      O_ALARM_O <= 1'b0;
      O_ALARM_OE <= latched_nxt;
    end
  end

  alarm_blinker #(
    .QUARTER_CYC(QUARTER_CYC)
  ) u_blink (
    .clk(I_CLK),
    .nrst(I_NRST),
    .ce(I_CE),
    .i_cls(cls_r),
    .o_led(O_LED)
  );

  // Exception reply sender
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_idx_nxt = tx_idx_r;
    tx_adr_nxt = tx_adr_r;
    tx_fn_nxt = tx_fn_r;
    tx_exc_nxt = tx_exc_r;
    tx_lrc_nxt = tx_lrc_r;
    tx_valid_nxt = O_TX_VALID;
    tx_char_nxt = O_TX_CHAR;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (reply) begin
          tx_adr_nxt = frm_addr;
          tx_fn_nxt = frm_func | FN_EXC_FLAG;
          tx_exc_nxt = exc;
          tx_lrc_nxt = 8'h00 - (frm_addr + (frm_func | FN_EXC_FLAG) + exc);
          tx_idx_nxt = 4'h0;
          tx_valid_nxt = 1'b1;
          tx_char_nxt = ASC_COLON;
          tx_st_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (I_TX_READY) begin
          if (tx_idx_r == EXC_LAST) begin
            tx_valid_nxt = 1'b0;
            tx_st_nxt = TX_IDLE;
          end else begin
            tx_idx_nxt = tx_idx_r + 4'h1;
            tx_char_nxt = exc_char(tx_idx_r + 4'h1, tx_adr_r, tx_fn_r, tx_exc_r, tx_lrc_r);
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      tx_st_r <= TX_IDLE;
      tx_idx_r <= 4'h0;
      tx_adr_r <= 8'h00;
      tx_fn_r <= 8'h00;
      tx_exc_r <= 8'h00;
      tx_lrc_r <= 8'h00;
      O_TX_VALID <= 1'b0;
      O_TX_CHAR <= 8'h00;
    end else if (I_CE) begin
      tx_st_r <= tx_st_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_adr_r <= tx_adr_nxt;
      tx_fn_r <= tx_fn_nxt;
      tx_exc_r <= tx_exc_nxt;
      tx_lrc_r <= tx_lrc_nxt;
      O_TX_VALID <= tx_valid_nxt;
      O_TX_CHAR <= tx_char_nxt;
    end
  end
endmodule

// >>> fault_alarm_asserts.sv
`timescale 1ns/1ns
module fault_alarm_asserts import fault_pkg::*; (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Serial reply
  input wire logic I_TX_READY,
  input wire logic O_TX_VALID,
  input wire logic [7:0] O_TX_CHAR,
  // Protection pins
  input wire logic I_OVERCUR,
  input wire logic I_OVERVOLT,
  input wire logic I_UNDERVOLT,
  input wire logic I_OVERHEAT,
  input wire logic I_OVERLOAD,
  input wire logic I_THERMAL,
  input wire logic I_HW_FAULT,
  input wire logic I_STOP_SW,
  input wire logic [7:0] I_DIP,
  // Drive and alarm
  input wire logic O_DRIVE_EN,
  input wire logic O_ALARM_O,
  input wire logic O_ALARM_OE
);
  logic any_flt;
  assign any_flt = I_OVERCUR | I_OVERVOLT | I_UNDERVOLT | I_OVERHEAT | I_OVERLOAD | I_THERMAL
    | I_HW_FAULT;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  sequence clean_stop;
    (I_STOP_SW && !any_flt) [*5];
  endsequence
  sequence trip_seen;
    ##[1:6] O_ALARM_OE;
  endsequence
  chk_alarm_pin_low: assert property (
    O_ALARM_O == 1'b0) else $error("alarm pin value not low");
  chk_stop_excl: assert property (
    O_ALARM_OE |-> !O_DRIVE_EN) else $error("drive on while alarm latched");
  chk_overcur_trip: assert property (
    $rose(I_OVERCUR) |-> trip_seen) else $error("overcurrent did not trip");
  chk_volt_stop: assert property (
    $rose(I_OVERVOLT) || $rose(I_UNDERVOLT) |-> ##[1:6] !O_DRIVE_EN) else $error("volt no stop");
  chk_heat_trip: assert property (
    $rose(I_OVERHEAT) |-> trip_seen) else $error("overheat did not trip");
  chk_load_trip: assert property (
    $rose(I_OVERLOAD) || $rose(I_THERMAL) |-> trip_seen) else $error("overload did not trip");
  chk_setting_trip: assert property (
    O_DRIVE_EN && $changed(I_DIP) |-> trip_seen) else $error("switch change did not trip");
  chk_stop_clears: assert property (
    clean_stop |-> !O_ALARM_OE) else $error("stop switch did not clear");
  chk_reply_start: assert property (
    $rose(O_TX_VALID) |-> O_TX_CHAR == ASC_COLON) else $error("reply not opened by colon");
  chk_char_hold: assert property (
    O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_CHAR)) else $error("char not held");
endmodule
bind modbus_fault_alarm_logic fault_alarm_asserts i_chk (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_TX_READY(I_TX_READY), .O_TX_VALID(O_TX_VALID), .O_TX_CHAR(O_TX_CHAR),
  .I_OVERCUR(I_OVERCUR), .I_OVERVOLT(I_OVERVOLT), .I_UNDERVOLT(I_UNDERVOLT),
  .I_OVERHEAT(I_OVERHEAT), .I_OVERLOAD(I_OVERLOAD), .I_THERMAL(I_THERMAL),
  .I_HW_FAULT(I_HW_FAULT), .I_STOP_SW(I_STOP_SW), .I_DIP(I_DIP), .O_DRIVE_EN(O_DRIVE_EN),
  .O_ALARM_O(O_ALARM_O), .O_ALARM_OE(O_ALARM_OE));

// >>> modbus_master_model.sv
`timescale 1ns/1ns
module modbus_master_model import fault_pkg::*; (
  // Clock
  input wire logic clk,
  // Characters to the device
  output logic o_rx_valid,
  output logic [7:0] o_rx_char,
  // Reply from the device
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_char,
  output logic o_tx_ready
);
  logic [7:0] rep[$];
  logic slow = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_char = 8'h00;
    o_tx_ready = 1'b0;
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n > 4'h9) ? 8'h37 + {4'h0, n} : 8'h30 + {4'h0, n};
  endfunction
  // Reply taken, stalling at random
  always @(posedge clk) begin
    if (i_tx_valid && o_tx_ready) rep.push_back(i_tx_char);
    o_tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
  end
  task automatic put(input logic [7:0] c);
    @(posedge clk);
    o_rx_valid <= 1'b1;
    o_rx_char <= c;
    @(posedge clk);
    o_rx_valid <= 1'b0;
    o_rx_char <= ~c;
  endtask
  task automatic send(input logic [7:0] a, f, input logic [15:0] r, d, input logic bad);
    logic [7:0] b[7];
    int i;
    b = '{a, f, r[15:8], r[7:0], d[15:8], d[7:0], 8'h00};
    for (i = 0; i < 6; i++) b[6] = b[6] - b[i];
    b[6] = b[6] ^ {7'h0, bad};
    put(ASC_COLON);
    for (i = 0; i < 7; i++) begin
      put(hx(b[i][7:4]));
      put(hx(b[i][3:0]));
    end
    put(ASC_CR);
    put(ASC_LF);
  endtask
endmodule

// >>> modbus_fault_alarm_logic_bench.sv
`timescale 1ns/1ns
module modbus_fault_alarm_logic_bench import fault_pkg::*; ;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, pen, pwr, pready, pslverr, rxv, txr, txv, stp, run, drv, aoe, err, led;
  logic [7:0] paddr, rxc, txc, dip, a, f;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] flt;
  int n_errors = 0;
  int n_checks = 0;
  int r, j, k, m;
  always #25 clk = ~clk;
  modbus_fault_alarm_logic #(.MS_CYC(1024), .QUARTER_CYC(4)) i_dut (.I_CLK(clk), .I_NRST(nrst),
    .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_RX_VALID(rxv), .I_RX_CHAR(rxc), .I_TX_READY(txr), .O_TX_VALID(txv), .O_TX_CHAR(txc),
    .I_OVERCUR(flt[0]), .I_OVERVOLT(flt[1]), .I_UNDERVOLT(flt[2]), .I_OVERHEAT(flt[3]),
    .I_OVERLOAD(flt[4]), .I_THERMAL(flt[5]), .I_HW_FAULT(flt[6]), .I_STOP_SW(stp),
    .I_RUN_TERM(run), .I_DIP(dip), .O_DRIVE_EN(drv), .O_ALARM_O(), .O_ALARM_OE(aoe), .O_LED(led));
  modbus_master_model i_mst (.clk(clk), .o_rx_valid(rxv), .o_rx_char(rxc), .i_tx_valid(txv),
    .i_tx_char(txc), .o_tx_ready(txr));
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 40 && pready !== 1'b1; i++) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 40) begin
      n_errors++;
      wrap_up;
    end
  endtask
  function automatic logic [7:0] exp_char(input logic [31:0] w, input int i);
    logic [7:0] b;
    if (i == 0) return ASC_COLON;
    if (i == 9) return ASC_CR;
    if (i == 10) return ASC_LF;
    b = w[31 - 8 * ((i - 1) / 2) -: 8];
    return i_mst.hx((i % 2 == 1) ? b[7:4] : b[3:0]);
  endfunction
  function automatic logic [2:0] cls_of(input int i);
    case (i)
      0: return CLS_OVERCUR;
      1: return CLS_OVERVOLT;
      2: return CLS_UNDERVOLT;
      3: return CLS_OVERHEAT;
      4, 5: return CLS_OVERLOAD;
      6: return CLS_HWFAIL;
      default: return CLS_SETTING;
    endcase
  endfunction
  // Frame out, then the reply compared char by char, or checked absent when code is 00
  task automatic exc(input logic [7:0] ad, fn, input logic [15:0] rg, d, input logic bad,
      input logic [7:0] code);
    logic [31:0] w;
    int i;
    w = {ad, fn | FN_EXC_FLAG, code, 8'h00 - ad - (fn | FN_EXC_FLAG) - code};
    i_mst.rep.delete();
    i_mst.send(ad, fn, rg, d, bad);
    for (i = 0; i < 400 && i_mst.rep.size() < 11; i++) @(posedge clk);
    if (code == 8'h00) begin
      chk("silent", 0, i_mst.rep.size());
    end else if (i_mst.rep.size() != 11) begin
      n_errors++;
      wrap_up;
    end else begin
      for (i = 0; i < 11; i++) chk("reply", exp_char(w, i), i_mst.rep[i]);
    end
  endtask
  initial begin
    r = $urandom(99223);
    {psel, pen, pwr, paddr, pwdata, flt, stp, run, dip} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", {16'h0, SLAVE_RST, 8'h00}, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 1, err);
    apb(1'b1, ADDR_WDT_LIMIT, 32'hffff);
    repeat (2100) @(posedge clk);
    apb(1'b0, ADDR_WDT_COUNT, 32'h0);
    chk("wdt runs", 1, rd > 32'h1);
    exc(SLAVE_RST, FN_READ, REG_STAT_FIRST, 16'h0001, 1'b0, 8'h00);
    apb(1'b0, ADDR_WDT_COUNT, 32'h0);
    chk("wdt clear", 0, rd);
    f = 8'($urandom);
    if (f == FN_READ || f == FN_WRITE) f = 8'h41;
    a = SLAVE_RST ^ (8'($urandom) | 8'h02);
    exc(SLAVE_RST, f, REG_CMD, 16'h0, 1'b0, EXC_FUNC);
    i_mst.slow = 1'b1;
    exc(SLAVE_RST, FN_WRITE, 16'h3000, 16'h0, 1'b0, EXC_ADDR);
    exc(SLAVE_RST, FN_WRITE, REG_CMD, 16'h0004, 1'b0, EXC_DATA);
    exc(SLAVE_RST, FN_WRITE, REG_FREQ, 16'($urandom), 1'b1, EXC_LRC);
    exc(a, 8'h41, REG_CMD, 16'h0, 1'b0, 8'h00);
    apb(1'b1, ADDR_CTRL, 32'h0000_0102);
    exc(SLAVE_RST, FN_READ, REG_STAT_FIRST, 16'h0001, 1'b0, EXC_COMM);
    apb(1'b1, ADDR_CTRL, 32'h0000_0100);
    r = $urandom % 8;
    for (k = 0; k < 8; k++) begin
      j = (k + r) % 8;
      m = (j == 7) ? 0 : j % 3;
      run <= 1'b1;
      stp <= 1'b0;
      repeat (6) @(posedge clk);
      chk("drive on", 1, drv);
      if (j == 7) dip <= dip ^ 8'h5a;
      else flt <= 7'(1 << j);
      repeat (6) @(posedge clk);
      chk("alarm on", 1, aoe);
      chk("drive off", 0, drv);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("class", cls_of(j), rd[3:1]);
      flt <= 7'h0;
      repeat (6) @(posedge clk);
      chk("held", 1, aoe);
      if (m == 0) stp <= 1'b1;
      else if (m == 1) run <= 1'b0;
      else exc(SLAVE_RST, FN_WRITE, REG_RESET, 16'h0002, 1'b0, 8'h00);
      repeat (6) @(posedge clk);
      chk("cleared", 0, aoe);
    end
    // Watchdog expiry trips as hardware class, register reset clears
    run <= 1'b1;
    stp <= 1'b0;
    apb(1'b1, ADDR_WDT_LIMIT, 32'h1);
    repeat (2100) @(posedge clk);
    chk("wdt alarm", 1, aoe);
    chk("wdt drive", 0, drv);
    chk("hw led", 1, led);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("wdt class", {CLS_HWFAIL, 1'b1}, rd[3:0]);
    chk("wdt flag", 1, rd[5]);
    apb(1'b1, ADDR_WDT_LIMIT, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0101);
    repeat (6) @(posedge clk);
    chk("reg reset", 0, aoe);
    chk("led off", 0, led);
    chk("drive back", 1, drv);
    wrap_up;
  end
endmodule
